// File: design/nvc_busy_if.sv
// interface: synchronised busy line view shared by controller modules
`timescale 1ns/1ps
`default_nettype none
interface nvc_busy_if;
  logic busy;
  logic busy_fall;
  logic busy_rise;
  modport src (output busy, output busy_fall, output busy_rise);
  modport dst (input busy, input busy_fall, input busy_rise);
endinterface
`default_nettype wire

// File: design/nvc_busy_sync.sv
// busy line input synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module nvc_busy_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  nvc_busy_if.src bus
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic low_q;
  // line is active low; change accepted once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= line_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      low_q <= ~s3_q;
    end
  end
  logic agree_low;
  assign agree_low = (s2_q == s3_q) && !s3_q;
  assign bus.busy = low_q;
  assign bus.busy_fall = agree_low && !low_q;
  assign bus.busy_rise = (s2_q == s3_q) && s3_q && low_q;
endmodule
`default_nettype wire

// File: design/nvc_host.sv
// host controller driving a nonvolatile sram through its pins
//
// Overview of operation
// - host may pull busy line low to request a save.
// - sequence save: five prefix reads then 0x0FC0.
// - sequence restore: same prefix then 0x0C63.
// - host steps sequences with reads only, output enable optional.
// - read: chip select and output enable low, write strobe high.
// - write: chip select and write strobe low, address held to rise.
// - prefix then 0x03F8 disables, 0x07F0 enables automatic save.
`timescale 1ns/1ps
`default_nettype none
module nvc_host #(
  parameter int unsigned SAVE_CYC = nvc_pkg::SAVE_CYC_DEF,
  parameter int unsigned PUP_CYC = nvc_pkg::PUP_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire nvc_pkg::nvc_cmd_type req_cmd_i,
  input wire logic [nvc_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  output logic busy_o,
  output logic [nvc_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_oe_n_o,
  output logic mem_we_n_o,
  input wire logic [7:0] mem_dq_i,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe_n_o,
  input wire logic store_busy_line_i,
  output logic store_busy_line_o,
  output logic store_busy_line_oe_n_o
);
  import nvc_pkg::*;

  // ---------------------------------------------------------------
  // busy line
  // ---------------------------------------------------------------
  nvc_busy_if bif ();
  nvc_busy_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(store_busy_line_i),
    .bus(bif)
  );

  typedef enum logic [3:0] {
    ST_PUP = 4'h0,
    ST_IDLE = 4'h1,
    ST_ACC = 4'h2,
    ST_GAP = 4'h3,
    ST_PULL = 4'h4,
    ST_WAIT = 4'h5,
    ST_SAVE = 4'h6,
    ST_RESTORE = 4'h7
  } nvc_state_type;

  function automatic logic [SEQ_W-1:0] seq_addr(input logic [2:0] i, input nvc_cmd_type c);
    logic [SEQ_W-1:0] a;
    a = SEQ_A0;
    case (i)
      3'h0: a = SEQ_A0;
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      default: begin
        case (c)
          CMD_SW_SAVE: a = SEQ_SAVE;
          CMD_SW_RESTORE: a = SEQ_RESTORE;
          CMD_AUTO_OFF: a = SEQ_AUTO_OFF;
          default: a = SEQ_AUTO_ON;
        endcase
      end
    endcase
    return a;
  endfunction

  // commands that run as a six-step read sequence
  function automatic logic is_seq_cmd(input nvc_cmd_type c);
    return (c == CMD_SW_SAVE) || (c == CMD_SW_RESTORE) ||
           (c == CMD_AUTO_OFF) || (c == CMD_AUTO_ON);
  endfunction

  nvc_state_type state_q;
  nvc_cmd_type cmd_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] step_q;
  logic is_seq;
  logic is_wr_q;

  assign is_seq = is_seq_cmd(cmd_q);
  // new requests only while idle and line high; writes wait out any save
  assign req_ready_o = (state_q == ST_IDLE) && !bif.busy;
  assign busy_o = (state_q != ST_IDLE);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_PUP;
      cmd_q <= CMD_READ;
      cnt_q <= '0;
      step_q <= 3'h0;
      is_wr_q <= 1'b0;
    end else begin
      case (state_q)
        ST_PUP: begin
          // wait out the power-up restore before any access
          if (cnt_q >= CNT_W'(PUP_CYC - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            cmd_q <= req_cmd_i;
            step_q <= 3'h0;
            cnt_q <= '0;
            is_wr_q <= (req_cmd_i == CMD_WRITE);
            state_q <= (req_cmd_i == CMD_HW_SAVE) ? ST_PULL : ST_ACC;
          end else if (bif.busy) begin
            // device-started save: hold off until the line rises
            state_q <= ST_WAIT;
          end
        end
        ST_ACC: begin
          if (cnt_q >= CNT_W'(ACCESS_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_GAP: begin
          // strobes high one cycle: each step is its own chip-select read
          cnt_q <= '0;
          if (is_seq && step_q != 3'(SEQ_LEN - 1)) begin
            step_q <= step_q + 3'h1;
            state_q <= ST_ACC;
          end else if (cmd_q == CMD_SW_SAVE) begin
            state_q <= ST_SAVE;
          end else if (cmd_q == CMD_SW_RESTORE) begin
            state_q <= ST_RESTORE;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_PULL: begin
          // hold the line low past the store request delay
          if (cnt_q >= CNT_W'(DELAY_CYC)) begin
            cnt_q <= '0;
            state_q <= ST_WAIT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WAIT: begin
          // device keeps line low for the save; skipped saves release it
          if (!bif.busy) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SAVE: begin
          if (cnt_q >= CNT_W'(SAVE_CYC - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RESTORE: begin
          if (cnt_q >= CNT_W'(RESTORE_CYC - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic acc;
  assign acc = (state_q == ST_ACC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o <= '0;
      mem_dq_o <= 8'h00;
    end else if (req_valid_i && req_ready_o) begin
      // a sequence opens on its first fixed address, not the request's
      mem_addr_o <= is_seq_cmd(req_cmd_i) ? {1'b0, SEQ_A0} : req_addr_i;
      mem_dq_o <= req_wdata_i;
    end else if (state_q == ST_GAP && is_seq) begin
      // msb left zero; only low lines are matched by the device
      mem_addr_o <= {1'b0, seq_addr(step_q + 3'h1, cmd_q)};
    end
  end

  // sequence reads leave output enable high: chip select times them
  assign mem_ce_n_o = !acc;
  assign mem_oe_n_o = !(acc && cmd_q == CMD_READ);
  // strobe rises with chip select, after which the address may move
  assign mem_we_n_o = !(acc && is_wr_q);
  assign mem_dq_oe_n_o = !(acc && is_wr_q);
  assign store_busy_line_o = 1'b0;
  assign store_busy_line_oe_n_o = !(state_q == ST_PULL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      rsp_valid_o <= (state_q == ST_GAP) && (!is_seq || step_q == 3'(SEQ_LEN - 1)) &&
                     (cmd_q != CMD_SW_SAVE) && (cmd_q != CMD_SW_RESTORE);
      if (state_q == ST_ACC && cmd_q == CMD_READ && cnt_q == CNT_W'(ACCESS_CYC - 1)) begin
        rsp_rdata_o <= mem_dq_i;
      end
    end
  end
  // completion for saves/restores is signalled by busy_o falling

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_enter_save;
    state_q == ST_GAP && cmd_q == CMD_SW_SAVE && step_q == 3'(SEQ_LEN - 1);
  endsequence
  AST_SEQ_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_enter_save |=> state_q == ST_SAVE) else $error("save did not follow sequence");
  AST_NO_WRITE_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_ready_o) |-> !bif.busy) else $error("request taken while busy");
  AST_PULL_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_PULL |-> !store_busy_line_oe_n_o && !store_busy_line_o)
    else $error("busy line not pulled");
  AST_SEQ_NO_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && is_seq) |-> mem_oe_n_o && mem_we_n_o) else $error("sequence step not a read");
  AST_SAVE_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_q == ST_SAVE) |-> !req_ready_o [*8]) else $error("access during save");
  AST_RESTORE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RESTORE |-> mem_ce_n_o) else $error("chip selected during restore");
  AST_ADDR_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && $past(acc)) |-> $stable(mem_addr_o)) else $error("address moved in access");
  AST_STEP_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && is_seq) |-> mem_addr_o[SEQ_W-1:0] == seq_addr(step_q, cmd_q))
    else $error("wrong sequence address");
  AST_LINE_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
    bif.busy_fall |=> !req_ready_o) else $error("request path open after line fell");
  AST_LINE_FREE: assert property (@(posedge clk_i) disable iff (rst_i)
    (bif.busy_rise && state_q == ST_WAIT) |-> ##2 state_q == ST_IDLE)
    else $error("wait state not left after line rose");
endmodule
`default_nettype wire

// File: design/nvc_pkg.sv
// package: constants for the nonvolatile sram host controller
package nvc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // ---------------------------------------------------------------
  // timing (ns) and derived cycle counts
  // ---------------------------------------------------------------
  localparam int unsigned STORE_REQUEST_DELAY_NS = 25000;
  localparam int unsigned SAVE_DURATION_NS = 15000000;
  localparam int unsigned RESTORE_DURATION_NS = 200000;
  localparam int unsigned POWERUP_RESTORE_DURATION_NS = 20000000;
  localparam int unsigned ACCESS_NS = 80;
  localparam int unsigned CYC_NS = 1000000000 / CLK_HZ;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CYC_NS - 1) / CYC_NS;
  localparam int unsigned RESTORE_CYC = (RESTORE_DURATION_NS + CYC_NS - 1) / CYC_NS;
  localparam int unsigned DELAY_CYC = (STORE_REQUEST_DELAY_NS + CYC_NS - 1) / CYC_NS;
  localparam int unsigned SAVE_CYC_DEF = (SAVE_DURATION_NS + CYC_NS - 1) / CYC_NS;
  localparam int unsigned PUP_CYC_DEF = (POWERUP_RESTORE_DURATION_NS + CYC_NS - 1) / CYC_NS;
  localparam int unsigned CNT_W = 24;
  // ---------------------------------------------------------------
  // command sequence addresses (low 14 bits compared)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned SEQ_W = 14;
  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
  localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
  localparam logic [13:0] SEQ_AUTO_OFF = 14'h03f8;
  localparam logic [13:0] SEQ_AUTO_ON = 14'h07f0;
  localparam int unsigned SEQ_LEN = 6;
  // host commands
  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_SW_SAVE = 3'h2,
    CMD_SW_RESTORE = 3'h3,
    CMD_AUTO_OFF = 3'h4,
    CMD_AUTO_ON = 3'h5,
    CMD_HW_SAVE = 3'h6
  } nvc_cmd_type;
endpackage

// File: testbench/nvc_dev_model.sv
// behavioural model of the nonvolatile sram device on the far side
`timescale 1ns/1ps
`default_nettype none
module nvc_dev_model #(
  parameter int unsigned SAVE_CYC = 15,
  parameter int unsigned DLY_CYC = 600
) (
  input wire logic clk_i,
  input wire logic [14:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  input wire logic line_i,
  output logic line_oe_n_o,
  input wire logic pwr_fail_i
);
  import nvc_pkg::*;
  localparam logic [13:0] SEQ [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [7:0] sram [32768];
  logic [7:0] nv [32768];
  logic [7:0] last_q = 8'h00;
  logic [2:0] step_q = 3'h0;
  logic ce_q = 1'b1;
  logic pf_q = 1'b0;
  logic dirty_q = 1'b0;
  logic auto_en_q = 1'b1;
  int save_q = 0;
  int dly_q = 0;
  int nsave_q = 0;
  logic rd;
  // -------------------------------------------------
  // array and pins
  // -------------------------------------------------
  initial begin
    for (int i = 0; i < 32768; i++) begin
      nv[i] = i[7:0] ^ 8'h5a;
      sram[i] = nv[i];
    end
  end
  assign rd = !ce_n_i && !oe_n_i && we_n_i && line_i && save_q == 0;
  // undriven data toggles so a stale value never reads as valid
  assign dq_o = rd ? sram[addr_i] : ~last_q;
  assign line_oe_n_o = (save_q == 0);
  always @(posedge clk_i) begin
    last_q <= dq_o;
    ce_q <= ce_n_i;
    pf_q <= pwr_fail_i;
    if (save_q != 0) begin
      save_q <= save_q - 1;
      if (save_q == 1) begin
        for (int i = 0; i < 32768; i++) nv[i] <= sram[i];
        dirty_q <= 1'b0;
        nsave_q <= nsave_q + 1;
      end
    end else begin
      dly_q <= line_i ? 0 : dly_q + 1;
      if (!line_i && dly_q == DLY_CYC && dirty_q) save_q <= SAVE_CYC;
      if (pwr_fail_i && !pf_q && auto_en_q && dirty_q) save_q <= SAVE_CYC;
      if (!ce_n_i && !we_n_i && line_i && !pwr_fail_i) begin
        sram[addr_i] <= dq_i;
        dirty_q <= 1'b1;
        step_q <= 3'h0;
      end else if (!ce_n_i && ce_q && we_n_i) begin
        if (step_q == 3'h5) begin
          step_q <= 3'h0;
          case (addr_i[13:0])
            SEQ_SAVE: save_q <= SAVE_CYC;
            SEQ_RESTORE: begin
              for (int i = 0; i < 32768; i++) sram[i] <= nv[i];
              dirty_q <= 1'b0;
            end
            SEQ_AUTO_OFF: auto_en_q <= 1'b0;
            SEQ_AUTO_ON: auto_en_q <= 1'b1;
            default: ;
          endcase
        end else if (addr_i[13:0] == SEQ[step_q]) step_q <= step_q + 3'h1;
        else step_q <= (addr_i[13:0] == SEQ_A0) ? 3'h1 : 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_nvc_host.sv
// self-checking testbench for the nonvolatile sram host controller
`timescale 1ns/1ps
`default_nettype none
module test_nvc_host;
  import nvc_pkg::*;
  localparam int unsigned SC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic pwr_fail = 1'b0;
  logic low_seen = 1'b0;
  nvc_cmd_type req_cmd_i = CMD_READ;
  logic [14:0] req_addr_i = '0;
  logic [7:0] req_wdata_i = '0;
  logic req_ready_o, rsp_valid_o, busy_o, ce_n, oe_n, we_n, dq_oe_n, bl_oe_n, bl_o, dev_oe_n;
  logic [7:0] rsp_rdata_o, dq_h, dq_d;
  logic [14:0] addr;
  int fail_count = 0;
  int compares = 0;
  // pull-up on the shared busy line
  wire logic line = (bl_oe_n | bl_o) & dev_oe_n;
  nvc_host #(.SAVE_CYC(SC), .PUP_CYC(SC)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .mem_addr_o(addr), .mem_ce_n_o(ce_n),
    .mem_oe_n_o(oe_n), .mem_we_n_o(we_n), .mem_dq_i(dq_d), .mem_dq_o(dq_h),
    .mem_dq_oe_n_o(dq_oe_n), .store_busy_line_i(line), .store_busy_line_o(bl_o),
    .store_busy_line_oe_n_o(bl_oe_n));
  nvc_dev_model #(.DLY_CYC(DELAY_CYC - 10)) dev (.clk_i(clk_i), .addr_i(addr),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_oe_n ? ~dq_h : dq_h), .dq_o(dq_d),
    .line_i(line), .line_oe_n_o(dev_oe_n), .pwr_fail_i(pwr_fail));
  initial forever #20 clk_i = ~clk_i;
  always @(negedge clk_i) if (!line) low_seen = 1'b1;
  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // holds the request until ready is seen, then waits for its answer
  task automatic req(input nvc_cmd_type c, input logic [14:0] a, input logic [7:0] d,
                     output int n);
    logic pulse;
    logic done;
    pulse = c inside {CMD_READ, CMD_WRITE, CMD_AUTO_OFF, CMD_AUTO_ON};
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_addr_i <= a;
    req_wdata_i <= d;
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    done = 1'b0;
    while (n < 9999 && !done) begin
      @(negedge clk_i);
      n++;
      done = pulse ? rsp_valid_o === 1'b1 : busy_o === 1'b0;
    end
    check("answer", done, 16'h1);
  endtask
  task automatic pulse_fail;
    @(posedge clk_i);
    pwr_fail <= 1'b1;
    @(posedge clk_i);
    pwr_fail <= 1'b0;
    repeat (5) @(negedge clk_i);
  endtask
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_rw;
    int n;
    @(negedge clk_i);
    check("busy_o", busy_o, 16'h1);
    req(CMD_WRITE, 15'h7abc, 8'h3c, n);
    req(CMD_READ, 15'h7abc, 8'h00, n);
    check("rdata", rsp_rdata_o, 16'h3c);
    check("latency", n[15:0], 16'(ACCESS_CYC + 2));
    req(CMD_READ, 15'h0010, 8'h00, n);
    check("pup data", rsp_rdata_o, 16'h4a);
    $display("test rw done");
  endtask
  task automatic t_sw;
    int n;
    int s = dev.nsave_q;
    req(CMD_WRITE, 15'h0100, 8'h11, n);
    low_seen = 1'b0;
    req(CMD_SW_SAVE, 15'h0000, 8'h00, n);
    check("nv byte", dev.nv[256], 16'h11);
    check("line low", low_seen, 16'h1);
    req(CMD_SW_SAVE, 15'h0000, 8'h00, n);
    check("saves", 16'(dev.nsave_q - s), 16'h2);
    req(CMD_WRITE, 15'h0100, 8'h22, n);
    req(CMD_SW_RESTORE, 15'h0000, 8'h00, n);
    req(CMD_READ, 15'h0100, 8'h00, n);
    check("restored", rsp_rdata_o, 16'h11);
    $display("test sw done");
  endtask
  task automatic t_hw;
    int n;
    int s = dev.nsave_q;
    req(CMD_HW_SAVE, 15'h0000, 8'h00, n);
    check("skip", 16'(dev.nsave_q - s), 16'h0);
    req(CMD_WRITE, 15'h0200, 8'h33, n);
    req(CMD_HW_SAVE, 15'h0000, 8'h00, n);
    check("hw save", 16'(dev.nsave_q - s), 16'h1);
    check("nv byte", dev.nv[512], 16'h33);
    $display("test hw done");
  endtask
  task automatic t_auto;
    int n;
    int s;
    req(CMD_AUTO_OFF, 15'h0000, 8'h00, n);
    check("auto en", dev.auto_en_q, 16'h0);
    req(CMD_WRITE, 15'h0300, 8'h44, n);
    s = dev.nsave_q;
    pulse_fail();
    check("no auto", 16'(dev.nsave_q - s), 16'h0);
    req(CMD_AUTO_ON, 15'h0000, 8'h00, n);
    check("auto en", dev.auto_en_q, 16'h1);
    pulse_fail();
    check("ready", req_ready_o, 16'h0);
    repeat (SC) @(negedge clk_i);
    check("auto save", 16'(dev.nsave_q - s), 16'h1);
    $display("test auto done");
  endtask
  task automatic t_seq;
    int n;
    int s = dev.nsave_q;
    logic [13:0] a [6] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_SAVE};
    for (int i = 0; i < 6; i++) begin
      req(CMD_READ, {1'b1, a[i]}, 8'h00, n);
      if (i == 2) req(CMD_WRITE, 15'h0400, 8'h55, n);
    end
    check("aborted", 16'(dev.nsave_q - s), 16'h0);
    for (int i = 0; i < 6; i++) req(CMD_READ, {1'b1, a[i]}, 8'h00, n);
    repeat (SC + 8) @(negedge clk_i);
    check("msb ignored", 16'(dev.nsave_q - s), 16'h1);
    $display("test seq done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rw();
    t_sw();
    t_hw();
    t_auto();
    t_seq();
    conclude();
  end
  // all scenarios need about 7k cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
